// *** cevec_regs.svh ***
// Vector numbers, vector layout and reset timing constants for the exception vectoring block
`ifndef CEVEC_REGS_SVH
`define CEVEC_REGS_SVH

`define CEVEC_VNUM_W 5
`define CEVEC_VEC_RESET 5'h00
`define CEVEC_VEC_RSVD_LO 5'h01
`define CEVEC_VEC_RSVD_HI 5'h06
`define CEVEC_VEC_NMI 5'h07
`define CEVEC_VEC_TRAP_BASE 5'h08
`define CEVEC_VEC_ABRK 5'h0c
`define CEVEC_VEC_IRQ_BASE 5'h0e
`define CEVEC_IRQ_COUNT 8
`define CEVEC_WDT_HOLD_CYC 8

`endif

// *** cevec_pkg.sv ***
// Types and vector address helper for the exception vectoring block
`include "cevec_regs.svh"

package cevec_pkg;
    typedef logic [`CEVEC_VNUM_W-1:0] cevec_vnum_type;

    typedef enum logic [2:0] {
        CEVEC_ST_RESET  = 3'h1,
        CEVEC_ST_LAUNCH = 3'h2,
        CEVEC_ST_RUN    = 3'h4
    } cevec_state_type;

    // Each vector holds a two-byte handler address
    function automatic logic [15:0] vec_addr(input cevec_vnum_type num);
        vec_addr = {10'h000, num, 1'b0};
    endfunction
endpackage

// *** cevec_prio.sv ***
// Priority selection among pending exception sources
`timescale 1ns/1ps
`include "cevec_regs.svh"

module cevec_prio #(
    parameter int IRQ_W = `CEVEC_IRQ_COUNT
) (
    // Candidate sources
    input wire logic nmi_i,
    input wire logic trap_i,
    input wire logic [1:0] trap_num_i,
    input wire logic abrk_i,
    input wire logic [IRQ_W-1:0] irq_i,
    // Winner
    output logic any_o,
    output cevec_pkg::cevec_vnum_type vnum_o
);
    always_comb begin
        any_o = 1'b1;
        vnum_o = `CEVEC_VEC_RESET; // RQ8
        if (nmi_i) begin
            vnum_o = `CEVEC_VEC_NMI; // RQ9
        end else if (trap_i) begin
            vnum_o = `CEVEC_VEC_TRAP_BASE + {3'h0, trap_num_i}; // RQ3
        end else if (abrk_i) begin
            vnum_o = `CEVEC_VEC_ABRK; // RQ9
        end else begin
            any_o = 1'b0;
            // Lowest index wins, so scan downward
            for (int i = IRQ_W - 1; i >= 0; i--) begin
                if (irq_i[i]) begin
                    any_o = 1'b1;
                    vnum_o = `CEVEC_VEC_IRQ_BASE + 5'(i); // RQ7
                end
            end
        end
    end
endmodule

// *** cevec_top.sv ***
// Exception acceptance and vectoring for the CPU instruction sequencer
// Function
// [RQ1] Reset is the highest exception and vector 0 is taken as soon as the clear pin is released.
// [RQ2] A watchdog overflow resets the chip and runs the very same reset sequence; the code adds a WDT_HOLD_CYC (8) cycle hold that pin reset lacks.
// [RQ3] A software trap forms its vector from its two-bit number, 0 to 3.
// [RQ4] Software traps are taken regardless of the interrupt mask bit.
// [RQ5] With the mask bit at 1 all interrupts but the non-maskable one and address break are held off.
// [RQ6] Interrupts are taken only once the current instruction or exception handling has completed.
// [RQ7] Of several pending interrupts the highest-priority one is served first.
// [RQ8] Vectors 1 to 6 are reserved and never produced.
// [RQ9] Non-maskable is vector 7, traps 8 to 11, address break 12, priority falling in that order.
// [RQ10] An accepted exception drives its two-byte vector address with a one-cycle accept strobe.
`timescale 1ns/1ps
`include "cevec_regs.svh"

module cevec_top #(
    parameter int IRQ_W = `CEVEC_IRQ_COUNT,
    parameter int WDT_HOLD_CYC = `CEVEC_WDT_HOLD_CYC
) (
    // Clock and chip reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Reset sources
    input wire logic chip_clear_pin_n_i,
    input wire logic wdt_overflow_i,
    // Sequencer
    input wire logic insn_boundary_i,
    input wire logic software_trap_insn_i,
    input wire logic [1:0] trap_num_i,
    input wire logic int_mask_i,
    // Interrupt sources
    input wire logic nmi_req_i,
    input wire logic addr_break_req_i,
    input wire logic [IRQ_W-1:0] irq_req_i,
    // Vector output
    output logic in_reset_o,
    output logic accept_o,
    output logic [15:0] vector_addr_o,
    output cevec_pkg::cevec_vnum_type vector_num_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic pin_meta_q, pin_meta_d;
    logic pin_sync_q, pin_sync_d;

    always_comb begin
        pin_meta_d = chip_clear_pin_n_i;
        pin_sync_d = pin_meta_q;
    end

    // Reset forces the pin view to asserted so release is seen cleanly
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending latches
    logic nmi_pend_q, nmi_pend_d;
    logic trap_pend_q, trap_pend_d;
    logic [1:0] trap_num_q, trap_num_d;
    logic sel_any;
    cevec_pkg::cevec_vnum_type sel_vnum;
    cevec_pkg::cevec_state_type state_q, state_d;
    logic take_nmi, take_trap, run, irq_window;
    logic [IRQ_W-1:0] irq_open;

    always_comb begin
        run = (state_q == cevec_pkg::CEVEC_ST_RUN);
        irq_window = run && insn_boundary_i; // RQ6
        irq_open = int_mask_i ? '0 : irq_req_i; // RQ5
        take_nmi = irq_window && nmi_pend_q;
        take_trap = run && trap_pend_q && !take_nmi;
        // Set wins over clear so a fresh event is never dropped in run; outside run the latches are held clear
        nmi_pend_d = (nmi_pend_q && !take_nmi) || nmi_req_i;
        trap_pend_d = (trap_pend_q && !take_trap) || software_trap_insn_i; // RQ4
        trap_num_d = software_trap_insn_i ? trap_num_i : trap_num_q;
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || state_q != cevec_pkg::CEVEC_ST_RUN) begin
            nmi_pend_q <= 1'b0;
            trap_pend_q <= 1'b0;
            trap_num_q <= 2'h0;
        end else begin
            nmi_pend_q <= nmi_pend_d;
            trap_pend_q <= trap_pend_d;
            trap_num_q <= trap_num_d;
        end
    end

    cevec_prio #(
        .IRQ_W(IRQ_W)
    ) u_prio (
        .nmi_i(take_nmi),
        .trap_i(run && trap_pend_q),
        .trap_num_i(trap_num_q),
        .abrk_i(irq_window && addr_break_req_i),
        .irq_i(irq_window ? irq_open : '0),
        .any_o(sel_any),
        .vnum_o(sel_vnum)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencing and vector output
    logic [7:0] hold_q, hold_d;
    logic accept_q, accept_d;
    logic in_reset_q, in_reset_d;
    cevec_pkg::cevec_vnum_type vnum_q, vnum_d;
    logic [15:0] vaddr_q, vaddr_d;

    always_comb begin
        state_d = state_q;
        hold_d = (hold_q != 8'h00) ? hold_q - 8'h01 : 8'h00;
        accept_d = 1'b0;
        vnum_d = vnum_q;
        in_reset_d = 1'b0;
        case (state_q)
            cevec_pkg::CEVEC_ST_RESET: begin
                in_reset_d = 1'b1;
                if (pin_sync_q && hold_q == 8'h00) begin
                    state_d = cevec_pkg::CEVEC_ST_LAUNCH; // RQ1
                end
            end
            cevec_pkg::CEVEC_ST_LAUNCH: begin
                accept_d = 1'b1;
                vnum_d = `CEVEC_VEC_RESET; // RQ1
                state_d = cevec_pkg::CEVEC_ST_RUN;
            end
            default: begin
                accept_d = sel_any; // RQ10
                if (sel_any) begin
                    vnum_d = sel_vnum; // RQ7
                end
            end
        endcase
        // Watchdog and pin override the state, reset flag and accept strobe
        if (wdt_overflow_i || !pin_sync_q) begin
            state_d = cevec_pkg::CEVEC_ST_RESET; // RQ2
            in_reset_d = 1'b1;
            accept_d = 1'b0;
        end
        if (wdt_overflow_i) begin
            hold_d = 8'(WDT_HOLD_CYC); // RQ2
        end
        vaddr_d = cevec_pkg::vec_addr(vnum_d); // RQ10
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_q <= cevec_pkg::CEVEC_ST_RESET;
            hold_q <= 8'h00;
            accept_q <= 1'b0;
            in_reset_q <= 1'b1;
            vnum_q <= `CEVEC_VEC_RESET;
            vaddr_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            hold_q <= hold_d;
            accept_q <= accept_d;
            in_reset_q <= in_reset_d;
            vnum_q <= vnum_d;
            vaddr_q <= vaddr_d;
        end
    end

    always_comb begin
        in_reset_o = in_reset_q;
        accept_o = accept_q;
        vector_num_o = vnum_q;
        vector_addr_o = vaddr_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // A fresh watchdog pulse or clear pin in launch restarts reset instead
    sequence s_released;
        state_q == cevec_pkg::CEVEC_ST_LAUNCH && !wdt_overflow_i && pin_sync_q;
    endsequence

    sequence s_reset_taken;
        ##1 (accept_o && vector_num_o == 5'h00 && vector_addr_o == 16'h0000);
    endsequence

    a_reset_vector_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ1
        s_released |-> s_reset_taken)
        else $error("Reset launch did not issue vector 0");

    a_wdt_reset_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ2
        wdt_overflow_i |=> in_reset_o [*8] ##1 (in_reset_o || state_q == cevec_pkg::CEVEC_ST_LAUNCH))
        else $error("Watchdog overflow did not hold the reset sequence");

    a_trap_vector_map: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ3
        (accept_o && vector_num_o >= 5'h08 && vector_num_o <= 5'h0b)
        |-> vector_addr_o == {10'h000, vector_num_o, 1'b0} && vector_addr_o >= 16'h0010)
        else $error("Trap vector address wrong");

    a_trap_unmasked: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ4
        (run && trap_pend_q && !take_nmi && !wdt_overflow_i && pin_sync_q)
        |=> accept_o && vector_num_o == 5'h08 + {3'h0, $past(trap_num_q)})
        else $error("Pending trap not accepted");

    a_irq_mask_hold: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ5
        (accept_o && vector_num_o >= 5'h0e) |-> !$past(int_mask_i))
        else $error("Masked interrupt accepted");

    a_irq_boundary: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ6
        (accept_o && (vector_num_o == 5'h07 || vector_num_o >= 5'h0c)) |-> $past(insn_boundary_i))
        else $error("Interrupt accepted off an instruction boundary");

    a_nmi_first: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ7
        (take_nmi && !wdt_overflow_i && pin_sync_q) |=> accept_o && vector_num_o == 5'h07)
        else $error("Non-maskable interrupt lost priority");

    a_no_reserved: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ8
        accept_o |-> !(vector_num_o >= 5'h01 && vector_num_o <= 5'h06))
        else $error("Reserved vector produced");

    a_abrk_order: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ9
        (irq_window && addr_break_req_i && !nmi_pend_q && !trap_pend_q && !wdt_overflow_i && pin_sync_q)
        |=> accept_o && vector_addr_o == 16'h0018)
        else $error("Address break not vectored to 12");

    a_accept_level: assert property (@(posedge ref_clk_i) disable iff (srst_i) // RQ10
        accept_o |-> !in_reset_o ##1 !(accept_o && vector_num_o == 5'h00))
        else $error("Accept strobe raised during reset or held on the reset vector");
endmodule

// *** cevec_seq_model.sv ***
// Instruction sequencer model that marks instruction boundaries
`timescale 1ns/1ps
module cevec_seq_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Control
    input wire logic hold_i,
    input wire logic accept_i,
    // Boundary
    output logic insn_boundary_o
);
    logic [1:0] cnt_q;
    // Quiet after an accept, while the handler entry runs
    always @(posedge ref_clk_i) begin
        if (srst_i || hold_i || accept_i) begin
            cnt_q <= 2'h0;
            insn_boundary_o <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            insn_boundary_o <= (cnt_q == 2'h3);
        end
    end
endmodule

// *** cpu_exception_vectoring_test.sv ***
// Self-checking bench for exception acceptance and vectoring
`timescale 1ns/1ps
module cpu_exception_vectoring_test;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic pin_n = 1'b1;
    logic wdt = 1'b0;
    logic bnd;
    logic hold = 1'b1;
    logic trap = 1'b0;
    logic [1:0] tnum = 2'h0;
    logic mask = 1'b1;
    logic nmi = 1'b0;
    logic abrk = 1'b0;
    logic [7:0] irq = 8'h00;
    logic in_rst;
    logic acc;
    logic [15:0] addr;
    cevec_pkg::cevec_vnum_type vnum;
    int errors = 0;
    int checked = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    cevec_top i_cevec_top (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .chip_clear_pin_n_i(pin_n),
        .wdt_overflow_i(wdt),
        .insn_boundary_i(bnd),
        .software_trap_insn_i(trap),
        .trap_num_i(tnum),
        .int_mask_i(mask),
        .nmi_req_i(nmi),
        .addr_break_req_i(abrk),
        .irq_req_i(irq),
        .in_reset_o(in_rst),
        .accept_o(acc),
        .vector_addr_o(addr),
        .vector_num_o(vnum)
    );

    cevec_seq_model i_cevec_seq_model (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .hold_i(hold),
        .accept_i(acc),
        .insn_boundary_o(bnd)
    );

    ////////////////////////////////////////
    task automatic bad(input string m);
        errors++;
        $display("BAD %0t %s", $time, m);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // Bounded wait, so a lost accept cannot hang the run
    task automatic expect_vec(input cevec_pkg::cevec_vnum_type n);
        int i;
        i = 0;
        do begin
            tick(1);
            i++;
        end while (acc !== 1'b1 && i < 20);
        checked++;
        if (acc !== 1'b1 || vnum !== n || addr !== {10'h000, n, 1'b0}) bad("wrong vector");
    endtask

    task automatic expect_none(input int n);
        repeat (n) begin
            tick(1);
            checked++;
            if (acc !== 1'b0) bad("unexpected accept");
        end
    endtask

    // Falling edge, so the registered outputs have settled
    always @(negedge ref_clk_i) begin
        if (acc === 1'b1 && vnum >= 5'h01 && vnum <= 5'h06) bad("reserved vector");
    end

    ////////////////////////////////////////
    task automatic s_reset;
        repeat (8) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        expect_vec(5'h00);
        tick(1);
        checked++;
        if (in_rst !== 1'b0) bad("still in reset");
        @(posedge ref_clk_i);
        pin_n <= 1'b0;
        expect_none(6);
        checked++;
        if (in_rst !== 1'b1) bad("pin low ignored");
        @(posedge ref_clk_i);
        pin_n <= 1'b1;
        expect_vec(5'h00);
    endtask

    // No boundaries and mask set: traps must still go
    task automatic s_traps;
        for (int n = 0; n < 4; n++) begin
            @(posedge ref_clk_i);
            trap <= 1'b1;
            tnum <= n[1:0];
            @(posedge ref_clk_i);
            trap <= 1'b0;
            expect_vec(5'h08 + 5'(n));
        end
    endtask

    task automatic s_mask;
        @(posedge ref_clk_i);
        hold <= 1'b0;
        irq <= 8'h01;
        expect_none(12);
        @(posedge ref_clk_i);
        abrk <= 1'b1;
        expect_vec(5'h0c);
        @(posedge ref_clk_i);
        abrk <= 1'b0;
        nmi <= 1'b1;
        @(posedge ref_clk_i);
        nmi <= 1'b0;
        expect_vec(5'h07);
        @(posedge ref_clk_i);
        hold <= 1'b1;
    endtask

    task automatic s_prio;
        @(posedge ref_clk_i);
        mask <= 1'b0;
        nmi <= 1'b1;
        abrk <= 1'b1;
        irq <= 8'h09;
        @(posedge ref_clk_i);
        nmi <= 1'b0;
        expect_none(6);
        @(posedge ref_clk_i);
        hold <= 1'b0;
        expect_vec(5'h07);
        expect_vec(5'h0c);
        @(posedge ref_clk_i);
        abrk <= 1'b0;
        expect_vec(5'h0e);
        @(posedge ref_clk_i);
        irq <= 8'h08;
        expect_vec(5'h11);
        @(posedge ref_clk_i);
        irq <= 8'h00;
        expect_none(8);
    endtask

    task automatic s_wdt;
        @(posedge ref_clk_i);
        wdt <= 1'b1;
        @(posedge ref_clk_i);
        wdt <= 1'b0;
        tick(1);
        checked++;
        if (in_rst !== 1'b1) bad("watchdog ignored");
        expect_vec(5'h00);
    endtask

    ////////////////////////////////////////
    task automatic complete_run;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        s_reset();
        s_traps();
        s_mask();
        s_prio();
        s_wdt();
        complete_run();
    end

    // Run needs about 120 cycles; 3000 is ample
    initial begin
        #75000;
        bad("timeout");
        complete_run();
    end
endmodule
